// ---- rtl/fault_query_pkg.sv ----
// Shared constants and command codes of the fault status and query unit
package fault_query_pkg;

    localparam int DATA_W = 16;
    localparam int EVT_W = 8;

    // Fault event bit positions, shared by status and enable mask
    localparam int SERIAL_LINK_TIMING_ERROR_BIT = 7;
    localparam int AMP_OVERCURRENT_BIT = 4;
    localparam int AMP_OVERVOLTAGE_BIT = 3;
    localparam int AMP_OVERTEMPERATURE_BIT = 2;
    localparam int AMP_CONSTANT_CURRENT_BIT = 1;
    localparam int OUTPUT_FAILURE_BIT = 0;
    localparam logic [7:0] FAULT_USED_MASK = 8'h9F;
    localparam logic [7:0] AMP_FAULT_MASK = 8'h1C;

    // Standard event register
    localparam int DEVICE_DEPENDENT_ERROR_BIT = 3;
    localparam logic [7:0] STD_USED_MASK = 8'hBD;

    // Status byte
    localparam int STANDARD_EVENT_SUMMARY_BIT = 5;
    localparam int UNIT_FAULT_SUMMARY_BIT = 1;

    localparam logic [7:0] FAULT_ENABLE_RESET = 8'h00;
    localparam logic [7:0] FAULT_STATUS_RESET = 8'h00;
    localparam logic [7:0] STD_ENABLE_RESET = 8'h00;
    localparam logic [7:0] STD_EVENT_RESET = 8'h00;
    localparam logic [15:0] VOLT_SETPOINT_RESET = 16'h0000;

    // Power factor ceiling, thousandths
    localparam logic [15:0] PF_MAX = 16'h03E7;

    // Configuration limit memory slots
    localparam logic [2:0] CFG_MIN_FREQ = 3'h0;
    localparam logic [2:0] CFG_MAX_FREQ = 3'h1;
    localparam logic [2:0] CFG_HIGH_CURRENT = 3'h2;
    localparam logic [2:0] CFG_LOW_CURRENT = 3'h3;
    localparam logic [2:0] CFG_HIGH_VOLTAGE = 3'h4;
    localparam logic [2:0] CFG_LOW_VOLTAGE = 3'h5;
    localparam int CFG_DEPTH = 6;

    // Phase selector: none means phase A
    localparam logic [1:0] PHASE_NONE = 2'h0;
    localparam logic [1:0] PHASE_A = 2'h1;
    localparam logic [1:0] PHASE_B = 2'h2;
    localparam logic [1:0] PHASE_C = 2'h3;

    typedef enum logic [4:0] {
        CMD_NONE,
        CMD_FAULT_ENABLE_SET,
        CMD_FAULT_ENABLE_QUERY,
        CMD_FAULT_STATUS_QUERY,
        CMD_CLEAR_STATUS,
        CMD_STD_ENABLE_SET,
        CMD_STD_ENABLE_QUERY,
        CMD_STD_EVENT_QUERY,
        CMD_STATUS_BYTE_QUERY,
        CMD_VOLTAGE_PROGRAM,
        CMD_MEAS_CURRENT,
        CMD_MEAS_VOLTAGE,
        CMD_MEAS_POWER,
        CMD_POWER_FACTOR_QUERY,
        CMD_MIN_FREQUENCY_QUERY,
        CMD_MAX_FREQUENCY_QUERY,
        CMD_HIGH_RANGE_CURRENT_LIMIT_QUERY,
        CMD_LOW_RANGE_CURRENT_LIMIT_QUERY,
        CMD_HIGH_RANGE_VOLTAGE_QUERY,
        CMD_LOW_RANGE_VOLTAGE_QUERY
    } cmd_type;

endpackage

// ---- rtl/config_limit_mem.sv ----
// Small memory holding configured frequency, current and voltage limits
`timescale 1ns/1ns
`default_nettype none
module config_limit_mem
    import fault_query_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = CFG_DEPTH
)
(
    input wire logic core_clk,
    input wire logic wrEn,
    input wire logic [2:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [2:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge core_clk)
    begin
        if (wrEn && (int'(wrAddr) < DEPTH))
        begin
            mem[wrAddr] <= wrData;
        end
        // Out-of-range reads return zero
        rdData <= (int'(rdAddr) < DEPTH) ? mem[rdAddr] : '0;
    end
endmodule // config_limit_mem
`default_nettype wire

// ---- rtl/fault_status_and_query_unit.sv ----
// Fault event registers, status byte and query answers of the AC source controller
//
// Overview of operation
// - Eight-bit fault enable mask, power-on zero
// - Enabled fault events ORed into summary bit
// - Fault bits 7,4,3,2,1,0 used; 6,5 unused
// - Mask and events share bit positions
// - Fault status read returns value, then clears
// - Read also releases latched amplifier faults
// - Persisting condition sets fault again
// - Amplifier fault forces zero volts, blocks programming
// - Program during fault rejected, device error set
// - Enable query returns current mask
// - Clear-status clears events, status byte, faults
// - Measurement queries take optional phase selector
// - Power factor magnitude capped at 0.999
// - Configuration limit queries; each range reads its own slot
// - Enabled standard events ORed into summary bit
`timescale 1ns/1ns
`default_nettype none
module fault_status_and_query_unit
    import fault_query_pkg::*;
#(
    parameter int PHASES = 3
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire cmd_type cmdCode,
    input wire logic [1:0] cmdPhase,
    input wire logic [DATA_W-1:0] cmdData,
    input wire logic [EVT_W-1:0] faultCond,
    input wire logic [EVT_W-1:0] stdEventIn,
    input wire logic [PHASES-1:0][DATA_W-1:0] measCurrent,
    input wire logic [PHASES-1:0][DATA_W-1:0] measVoltage,
    input wire logic [PHASES-1:0][DATA_W-1:0] measPower,
    input wire logic [PHASES-1:0][DATA_W-1:0] measPowerFactor,
    input wire logic cfgWrEn,
    input wire logic [2:0] cfgWrAddr,
    input wire logic [DATA_W-1:0] cfgWrData,
    output logic rspValid,
    output logic [DATA_W-1:0] rspData,
    output logic [EVT_W-1:0] statusByte,
    output logic unitFaultSummary,
    output logic standardEventSummary,
    output logic outputForceZero,
    output logic amplitudeProgEnable,
    output logic [DATA_W-1:0] voltSetpoint
);
    typedef struct packed {
        logic [EVT_W-1:0] faultEnable;
        logic [EVT_W-1:0] faultStatus;
        logic [EVT_W-1:0] stdEnable;
        logic [EVT_W-1:0] stdEvent;
        logic [DATA_W-1:0] voltProgram;
        logic p1Valid;
        logic p1FromMem;
        logic [DATA_W-1:0] p1Value;
        logic rspValid;
        logic [DATA_W-1:0] rspData;
        logic [EVT_W-1:0] statusByte;
        logic unitFaultSummary;
        logic standardEventSummary;
        logic forceZero;
        logic progEnable;
        logic [DATA_W-1:0] voltOut;
    } state_type;

    state_type st_r;
    state_type st_nxt;
    logic [2:0] cfgRdAddr;
    logic [DATA_W-1:0] cfgRdData;

    // Phase index; no selector means phase A
    function automatic int phaseIndex(input logic [1:0] sel);
        int idx;
        idx = (sel == PHASE_NONE) ? 0 : int'(sel) - 1;
        return (idx < PHASES) ? idx : 0;
    endfunction

    function automatic logic [DATA_W-1:0] widen(input logic [EVT_W-1:0] v);
        return {{(DATA_W-EVT_W){1'b0}}, v};
    endfunction

    config_limit_mem #(
        .WIDTH(DATA_W),
        .DEPTH(CFG_DEPTH)
    ) u_cfg (
        .core_clk(core_clk),
        .wrEn(cfgWrEn),
        .wrAddr(cfgWrAddr),
        .wrData(cfgWrData),
        .rdAddr(cfgRdAddr),
        .rdData(cfgRdData)
    );

    always_comb
    begin
        unique case (cmdCode)
            CMD_MIN_FREQUENCY_QUERY: cfgRdAddr = CFG_MIN_FREQ;
            CMD_MAX_FREQUENCY_QUERY: cfgRdAddr = CFG_MAX_FREQ;
            CMD_HIGH_RANGE_CURRENT_LIMIT_QUERY: cfgRdAddr = CFG_HIGH_CURRENT;
            CMD_LOW_RANGE_CURRENT_LIMIT_QUERY: cfgRdAddr = CFG_LOW_CURRENT;
            CMD_HIGH_RANGE_VOLTAGE_QUERY: cfgRdAddr = CFG_HIGH_VOLTAGE;
            CMD_LOW_RANGE_VOLTAGE_QUERY: cfgRdAddr = CFG_LOW_VOLTAGE;
            default: cfgRdAddr = CFG_MIN_FREQ;
        endcase
    end

    always_comb
    begin
        logic [EVT_W-1:0] faultClr;
        logic [EVT_W-1:0] stdClr;
        logic [EVT_W-1:0] stdSet;
        logic ampFault;
        logic [DATA_W-1:0] pf;
        int ph;
        faultClr = '0;
        stdClr = '0;
        stdSet = stdEventIn & STD_USED_MASK;
        ampFault = |(st_r.faultStatus & AMP_FAULT_MASK);
        ph = phaseIndex(cmdPhase);
        pf = measPowerFactor[ph];
        st_nxt = st_r;
        st_nxt.p1Valid = 1'b0;
        st_nxt.p1FromMem = 1'b0;
        st_nxt.p1Value = '0;
        if (cmdValid)
        begin
            unique case (cmdCode)
                CMD_FAULT_ENABLE_SET:
                begin
                    st_nxt.faultEnable = cmdData[EVT_W-1:0];
                end
                CMD_FAULT_ENABLE_QUERY:
                begin
                    st_nxt.p1Valid = 1'b1;
                    st_nxt.p1Value = widen(st_r.faultEnable);
                end
                CMD_FAULT_STATUS_QUERY:
                begin
                    st_nxt.p1Valid = 1'b1;
                    st_nxt.p1Value = widen(st_r.faultStatus);
                    faultClr = '1;
                end
                CMD_CLEAR_STATUS:
                begin
                    faultClr = '1;
                    stdClr = '1;
                end
                CMD_STD_ENABLE_SET:
                begin
                    st_nxt.stdEnable = cmdData[EVT_W-1:0];
                end
                CMD_STD_ENABLE_QUERY:
                begin
                    st_nxt.p1Valid = 1'b1;
                    st_nxt.p1Value = widen(st_r.stdEnable);
                end
                CMD_STD_EVENT_QUERY:
                begin
                    st_nxt.p1Valid = 1'b1;
                    st_nxt.p1Value = widen(st_r.stdEvent);
                    stdClr = '1;
                end
                CMD_STATUS_BYTE_QUERY:
                begin
                    st_nxt.p1Valid = 1'b1;
                    st_nxt.p1Value = widen(st_r.statusByte);
                end
                CMD_VOLTAGE_PROGRAM:
                begin
                    if (ampFault)
                    begin
                        stdSet[DEVICE_DEPENDENT_ERROR_BIT] = 1'b1;
                    end
                    else
                    begin
                        st_nxt.voltProgram = cmdData;
                    end
                end
                CMD_MEAS_CURRENT:
                begin
                    st_nxt.p1Valid = 1'b1;
                    st_nxt.p1Value = measCurrent[ph];
                end
                CMD_MEAS_VOLTAGE:
                begin
                    st_nxt.p1Valid = 1'b1;
                    st_nxt.p1Value = measVoltage[ph];
                end
                CMD_MEAS_POWER:
                begin
                    st_nxt.p1Valid = 1'b1;
                    st_nxt.p1Value = measPower[ph];
                end
                CMD_POWER_FACTOR_QUERY:
                begin
                    st_nxt.p1Valid = 1'b1;
                    st_nxt.p1Value = (pf > PF_MAX) ? PF_MAX : pf;
                end
                CMD_MIN_FREQUENCY_QUERY, CMD_MAX_FREQUENCY_QUERY,
                CMD_HIGH_RANGE_CURRENT_LIMIT_QUERY, CMD_LOW_RANGE_CURRENT_LIMIT_QUERY,
                CMD_HIGH_RANGE_VOLTAGE_QUERY, CMD_LOW_RANGE_VOLTAGE_QUERY:
                begin
                    st_nxt.p1Valid = 1'b1;
                    st_nxt.p1FromMem = 1'b1;
                end
                default:
                begin
                end
            endcase
        end
        // Clear first, then new events; set wins
        st_nxt.faultStatus = (st_r.faultStatus & ~faultClr)
            | (faultCond & FAULT_USED_MASK);
        st_nxt.stdEvent = (st_r.stdEvent & ~stdClr) | stdSet;
        // Answer stage
        st_nxt.rspValid = st_r.p1Valid;
        st_nxt.rspData = st_r.p1FromMem ? cfgRdData : st_r.p1Value;
        // Summaries from the updated event registers
        st_nxt.unitFaultSummary = |(st_nxt.faultStatus & st_nxt.faultEnable);
        st_nxt.standardEventSummary = |(st_nxt.stdEvent & st_nxt.stdEnable);
        st_nxt.statusByte = '0;
        st_nxt.statusByte[UNIT_FAULT_SUMMARY_BIT] = st_nxt.unitFaultSummary;
        st_nxt.statusByte[STANDARD_EVENT_SUMMARY_BIT] = st_nxt.standardEventSummary;
        st_nxt.forceZero = |(st_nxt.faultStatus & AMP_FAULT_MASK);
        st_nxt.progEnable = ~st_nxt.forceZero;
        st_nxt.voltOut = st_nxt.forceZero ? '0 : st_nxt.voltProgram;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '{
                faultEnable: FAULT_ENABLE_RESET,
                faultStatus: FAULT_STATUS_RESET,
                stdEnable: STD_ENABLE_RESET,
                stdEvent: STD_EVENT_RESET,
                voltProgram: VOLT_SETPOINT_RESET,
                p1Valid: 1'b0,
                p1FromMem: 1'b0,
                p1Value: '0,
                rspValid: 1'b0,
                rspData: '0,
                statusByte: '0,
                unitFaultSummary: 1'b0,
                standardEventSummary: 1'b0,
                forceZero: 1'b0,
                progEnable: 1'b1,
                voltOut: VOLT_SETPOINT_RESET
            };
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rspValid = st_r.rspValid;
    assign rspData = st_r.rspData;
    assign statusByte = st_r.statusByte;
    assign unitFaultSummary = st_r.unitFaultSummary;
    assign standardEventSummary = st_r.standardEventSummary;
    assign outputForceZero = st_r.forceZero;
    assign amplitudeProgEnable = st_r.progEnable;
    assign voltSetpoint = st_r.voltOut;
endmodule // fault_status_and_query_unit
`default_nettype wire

// ---- verification/fault_status_and_query_unit_properties.sv ----
// Port-level properties of the fault status and query unit
`timescale 1ns/1ns
`default_nettype none
module fault_status_and_query_unit_checker
    import fault_query_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire cmd_type cmdCode,
    input wire logic [DATA_W-1:0] cmdData,
    input wire logic [EVT_W-1:0] faultCond,
    input wire logic rspValid,
    input wire logic [DATA_W-1:0] rspData,
    input wire logic [EVT_W-1:0] statusByte,
    input wire logic unitFaultSummary,
    input wire logic standardEventSummary,
    input wire logic outputForceZero,
    input wire logic amplitudeProgEnable,
    input wire logic [DATA_W-1:0] voltSetpoint
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic ampCond;
    logic isQuery;
    logic pfCmd;
    logic isCmd;
    assign ampCond = |(faultCond & AMP_FAULT_MASK);
    assign isQuery = cmdValid && !(cmdCode inside {CMD_NONE, CMD_FAULT_ENABLE_SET,
        CMD_CLEAR_STATUS, CMD_STD_ENABLE_SET, CMD_VOLTAGE_PROGRAM});
    assign pfCmd = cmdValid && cmdCode == CMD_POWER_FACTOR_QUERY;
    assign isCmd = cmdValid && !ampCond;
    chk_rsp_latency: assert property (isQuery |-> ##2 rspValid)
        else $error("answer strobe missing two cycles after query");
    chk_force_zero: assert property (ampCond |=> outputForceZero)
        else $error("amplifier fault did not force zero output");
    chk_prog_inverse: assert property (amplitudeProgEnable == !outputForceZero)
        else $error("programming enable disagrees with forced zero");
    chk_volt_zero: assert property (outputForceZero |-> voltSetpoint == 16'h0000)
        else $error("setpoint not zero while forced");
    chk_stb_layout: assert property (statusByte == {2'h0, standardEventSummary, 3'h0,
        unitFaultSummary, 1'h0})
        else $error("status byte layout wrong");
    chk_prog_accept: assert property (isCmd && cmdCode == CMD_VOLTAGE_PROGRAM
        && !outputForceZero |=> voltSetpoint == $past(cmdData))
        else $error("accepted program not applied");
    chk_read_release: assert property (isCmd && cmdCode == CMD_FAULT_STATUS_QUERY
        |=> !outputForceZero)
        else $error("status read did not release amplifier fault");
    chk_clear_all: assert property (cmdValid && cmdCode == CMD_CLEAR_STATUS
        && (faultCond & FAULT_USED_MASK) == 8'h00 |=> !unitFaultSummary)
        else $error("clear status left fault summary set");
    chk_pf_cap: assert property (rspValid && $past(pfCmd, 2) |-> rspData <= PF_MAX)
        else $error("power factor above ceiling");
    cover property (ampCond ##1 outputForceZero);
    cover property (pfCmd ##2 rspValid);
    cover property (cmdValid && cmdCode == CMD_CLEAR_STATUS);
endmodule // fault_status_and_query_unit_checker
bind fault_status_and_query_unit fault_status_and_query_unit_checker chk (.core_clk, .rst_n,
    .cmdValid, .cmdCode, .cmdData, .faultCond, .rspValid, .rspData, .statusByte,
    .unitFaultSummary, .standardEventSummary, .outputForceZero, .amplitudeProgEnable,
    .voltSetpoint);
`default_nettype wire

// ---- verification/host_model.sv ----
// Behavioural host issuing parsed commands to the unit
`timescale 1ns/1ns
`default_nettype none
module host_model
    import fault_query_pkg::*;
(
    input wire logic core_clk,
    output logic cmdValid,
    output cmd_type cmdCode,
    output logic [1:0] cmdPhase,
    output logic [DATA_W-1:0] cmdData
);
    initial
    begin
        cmdValid = 1'b0;
        cmdCode = CMD_NONE;
        cmdPhase = 2'h0;
        cmdData = 16'h0000;
    end
    task automatic send(input cmd_type c, input logic [1:0] ph, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        #1;
        cmdValid = 1'b1;
        cmdCode = c;
        cmdPhase = ph;
        cmdData = d;
        @(posedge core_clk);
        #1;
        cmdValid = 1'b0;
        // Stale argument not left on the lines
        cmdPhase = ~ph;
        cmdData = ~d;
    endtask
endmodule // host_model
`default_nettype wire

// ---- verification/test_fault_status_and_query_unit.sv ----
// Self-checking bench of the fault status and query unit
`timescale 1ns/1ns
`default_nettype none
module test_fault_status_and_query_unit
    import fault_query_pkg::*;
;
    logic coreClk = 1'b0;
    logic rstN = 1'b0;
    logic cmdValid, rspValid, unitFaultSummary, standardEventSummary;
    logic outputForceZero, amplitudeProgEnable;
    cmd_type cmdCode;
    logic [1:0] cmdPhase;
    logic [15:0] cmdData, rspData, voltSetpoint;
    logic [7:0] faultCond = 8'h00;
    logic [7:0] stdEventIn = 8'h00;
    logic [7:0] statusByte;
    logic [2:0][15:0] measCurrent, measVoltage, measPower, measPowerFactor;
    logic cfgWrEn = 1'b0;
    logic [2:0] cfgWrAddr = 3'h0;
    logic [15:0] cfgWrData = 16'h0000;
    logic [15:0] expQ[$];
    int numErrors = 0;
    int checkCount = 0;
    int cycles = 0;
    always #20 coreClk = ~coreClk;
    host_model host (.core_clk(coreClk), .cmdValid, .cmdCode, .cmdPhase, .cmdData);
    fault_status_and_query_unit #(.PHASES(3)) uut (.core_clk(coreClk), .rst_n(rstN), .cmdValid,
        .cmdCode, .cmdPhase, .cmdData, .faultCond, .stdEventIn, .measCurrent, .measVoltage,
        .measPower, .measPowerFactor, .cfgWrEn, .cfgWrAddr, .cfgWrData, .rspValid, .rspData,
        .statusByte, .unitFaultSummary, .standardEventSummary, .outputForceZero,
        .amplitudeProgEnable, .voltSetpoint);
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checkCount++;
        if (g !== e)
        begin
            numErrors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick();
        @(posedge coreClk);
        #1;
    endtask
    task automatic q(input cmd_type c, input logic [1:0] ph, input logic [15:0] e);
        expQ.push_back(e);
        host.send(c, ph, 16'h0000);
    endtask
    task automatic printVerdict();
        $display("checks %0d errors %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Answer watcher pairs each strobe with the oldest note
    always @(posedge coreClk)
    begin
        cycles++;
        if (rspValid === 1'b1 && expQ.size() == 0)
            chk("answer count", 16'h0000, 16'h0001);
        else if (rspValid === 1'b1)
            chk("rspData", expQ.pop_front(), rspData);
        if (cycles == 3000)
        begin
            numErrors++;
            printVerdict();
        end
    end
    initial
    begin
        logic [7:0] en, bitv, used;
        logic amp;
        logic [15:0] volt, pf;
        logic [15:0] cfg[6];
        int k;
        void'($urandom(32'h1838));
        for (int i = 0; i < 3; i++)
            {measCurrent[i], measVoltage[i], measPower[i], measPowerFactor[i]} = {$urandom,
                $urandom};
        measPowerFactor[1] = 16'($urandom % 1000);
        repeat (20) @(posedge coreClk);
        #1 rstN = 1'b1;
        q(CMD_FAULT_ENABLE_QUERY, PHASE_NONE, 16'h0000);
        q(CMD_FAULT_STATUS_QUERY, PHASE_NONE, 16'h0000);
        en = 8'($urandom);
        host.send(CMD_FAULT_ENABLE_SET, PHASE_NONE, {8'h00, en});
        q(CMD_FAULT_ENABLE_QUERY, PHASE_NONE, {8'h00, en});
        for (int i = 0; i < 8; i++)
        begin
            bitv = 8'h01 << i;
            used = bitv & FAULT_USED_MASK;
            amp = |(bitv & AMP_FAULT_MASK);
            volt = 16'($urandom);
            host.send(CMD_FAULT_ENABLE_SET, PHASE_NONE, {8'h00, ~bitv});
            tick();
            faultCond = bitv;
            tick();
            faultCond = 8'h00;
            chk("summary", 16'h0000, 16'(unitFaultSummary));
            chk("forceZero", 16'(amp), 16'(outputForceZero));
            chk("progEnable", 16'(!amp), 16'(amplitudeProgEnable));
            host.send(CMD_FAULT_ENABLE_SET, PHASE_NONE, 16'h00FF);
            chk("summary", 16'(|used), 16'(unitFaultSummary));
            host.send(CMD_VOLTAGE_PROGRAM, PHASE_NONE, volt);
            chk("voltSetpoint", amp ? 16'h0000 : volt, voltSetpoint);
            q(CMD_STD_EVENT_QUERY, PHASE_NONE, amp ? 16'h0008 : 16'h0000);
            q(CMD_FAULT_STATUS_QUERY, PHASE_NONE, {8'h00, used});
            q(CMD_FAULT_STATUS_QUERY, PHASE_NONE, 16'h0000);
            chk("forceZero", 16'h0000, 16'(outputForceZero));
        end
        faultCond = 8'h04;
        q(CMD_FAULT_STATUS_QUERY, PHASE_NONE, 16'h0004);
        chk("forceZero", 16'h0001, 16'(outputForceZero));
        faultCond = 8'h00;
        host.send(CMD_STD_ENABLE_SET, PHASE_NONE, 16'h0008);
        host.send(CMD_VOLTAGE_PROGRAM, PHASE_NONE, 16'h0100);
        tick();
        chk("statusByte", 16'h0022, 16'(statusByte));
        chk("stdSummary", 16'h0001, 16'(standardEventSummary));
        host.send(CMD_CLEAR_STATUS, PHASE_NONE, 16'h0000);
        tick();
        chk("statusByte", 16'h0000, 16'(statusByte));
        chk("forceZero", 16'h0000, 16'(outputForceZero));
        q(CMD_STD_EVENT_QUERY, PHASE_NONE, 16'h0000);
        for (int ph = 0; ph < 4; ph++)
        begin
            k = (ph == 0) ? 0 : ph - 1;
            pf = (measPowerFactor[k] > PF_MAX) ? PF_MAX : measPowerFactor[k];
            q(CMD_MEAS_CURRENT, 2'(ph), measCurrent[k]);
            q(CMD_MEAS_VOLTAGE, 2'(ph), measVoltage[k]);
            q(CMD_MEAS_POWER, 2'(ph), measPower[k]);
            q(CMD_POWER_FACTOR_QUERY, 2'(ph), pf);
        end
        for (int s = 0; s < 6; s++)
        begin
            cfg[s] = 16'($urandom);
            tick();
            cfgWrEn = 1'b1;
            cfgWrAddr = 3'(s);
            cfgWrData = cfg[s];
        end
        tick();
        cfgWrEn = 1'b0;
        for (int s = 0; s < 6; s++)
            q(cmd_type'(CMD_MIN_FREQUENCY_QUERY + s), PHASE_NONE, cfg[s]);
        repeat (4) tick();
        // Mid-run reset returns the enable mask to zero
        rstN = 1'b0;
        repeat (2) tick();
        rstN = 1'b1;
        q(CMD_FAULT_ENABLE_QUERY, PHASE_NONE, 16'h0000);
        repeat (4) tick();
        chk("pending answers", 16'h0000, 16'(expQ.size()));
        printVerdict();
    end
endmodule // test_fault_status_and_query_unit
`default_nettype wire
